// [src/vop_pkg.sv]
package vop_pkg;

  // ------------------------------------------------------------
  // register map, byte addresses, one aligned 32-bit word each
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_FUNC21 = 8'h00;
  localparam logic [7:0] OFF_RB_HI = 8'h04;
  localparam logic [7:0] OFF_RB_LO = 8'h08;
  localparam logic [7:0] OFF_POL_BASE = 8'h0C;
  localparam logic [7:0] OFF_POL_LAST = 8'h50;
  localparam logic [7:0] OFF_CLR = 8'h54;

  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam int NUM_LO = 16;
  localparam int NUM_HI = 2;
  localparam int NUM_POL = 18;
  localparam int POL_BIT = 0;
  localparam int CLR_BIT = 0;
  localparam logic [17:0] POL_RST = 18'h00000;
  localparam logic [15:0] FUNC_RST = 16'h0000;
  localparam logic CLR_RST = 1'b1;
  localparam logic [4:0] IDX_NONE = 5'h1F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // terminal levels: outputs 1..16 low, 20 and 21 high
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] upper;
    logic [15:0] lower;
  } vop_levels_t;

  // polarity slot of an address, IDX_NONE when not a polarity word
  function automatic logic [4:0] pol_index(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - OFF_POL_BASE;
    if (addr[1:0] != 2'h0 || addr < OFF_POL_BASE || addr > OFF_POL_LAST) begin
      return IDX_NONE;
    end
    return rel[6:2];
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr[1:0] == 2'h0) && (addr <= OFF_CLR);
  endfunction

endpackage

// [src/vop_polarity.sv]
// Operation
// - polarity 0: terminal reads 1 while its selected function is active
// - polarity 1: terminal reads 0 while its selected function is active
// - one polarity bit per output 1-16, 20, 21; resets 0, writable anytime
// - read-only word gives present levels of outputs 1 to 16
// - separate read-only word gives present levels of outputs 20 and 21
// - power-on setting, default 1, clears virtual input value register at power-on
module vop_polarity #(
  parameter int ADDR_W = vop_pkg::ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire vop_pkg::vop_levels_t func_active,
  output vop_pkg::vop_levels_t virtual_out,
  output logic [15:0] func21_select,
  output logic vin_clear_enable,
  output logic vin_clear_pulse
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  generate
    // the decoder reads the low byte of every address, so narrower buses cannot work
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
      $error("vop_polarity: ADDR_W must lie between 8 and 32");
    end
  endgenerate

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [17:0] pol_q;
  logic [15:0] func21_q;
  logic clr_q;
  logic arm_q;
  logic pulse_q;
  vop_pkg::vop_levels_t vout_q;
  logic aw_hold_q;
  logic [7:0] aw_addr_q;
  logic w_hold_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic rd_fire;
  logic [4:0] wr_idx;
  logic [7:0] ar_addr;
  logic [4:0] rd_idx;

  // prot is accepted but not used: every register is open to any master
  assign ar_addr = s_axi_araddr[7:0];
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_idx = vop_pkg::pol_index(aw_addr_q);
  assign rd_idx = vop_pkg::pol_index(ar_addr);

  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign virtual_out = vout_q;
  assign func21_select = func21_q;
  assign vin_clear_enable = clr_q;
  assign vin_clear_pulse = pulse_q;

  // ------------------------------------------------------------
  // terminal levels
  // ------------------------------------------------------------
  // xor with polarity; one flop so the terminals never glitch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vout_q <= '0;
    end else begin
      vout_q <= func_active ^ pol_q;
    end
  end

  // ------------------------------------------------------------
  // write channel: address and data taken in either order
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr[7:0];
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= vop_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      // readback words are read-only; writing them is an error
      if (!vop_pkg::is_mapped(aw_addr_q) || aw_addr_q == vop_pkg::OFF_RB_HI || aw_addr_q == vop_pkg::OFF_RB_LO) begin
        bresp_q <= vop_pkg::RESP_SLVERR;
      end else begin
        bresp_q <= vop_pkg::RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol_q <= vop_pkg::POL_RST;
    end else if (wr_fire && wr_idx != vop_pkg::IDX_NONE && w_strb_q[0]) begin
      pol_q[wr_idx] <= w_data_q[vop_pkg::POL_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func21_q <= vop_pkg::FUNC_RST;
    end else if (wr_fire && aw_addr_q == vop_pkg::OFF_FUNC21) begin
      if (w_strb_q[0]) begin
        func21_q[7:0] <= w_data_q[7:0];
      end
      if (w_strb_q[1]) begin
        func21_q[15:8] <= w_data_q[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_q <= vop_pkg::CLR_RST;
    end else if (wr_fire && aw_addr_q == vop_pkg::OFF_CLR && w_strb_q[0]) begin
      clr_q <= w_data_q[vop_pkg::CLR_BIT];
    end
  end

  // ------------------------------------------------------------
  // power-on clear of the virtual input value register
  // ------------------------------------------------------------
  // one pulse per reset release; reset reloads the setting to 1, so later
  // writes never reach the next power-on and never clear inputs mid-run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_q <= 1'b1;
      pulse_q <= 1'b0;
    end else begin
      arm_q <= 1'b0;
      pulse_q <= arm_q && clr_q;
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    logic [4:0] idx;
    idx = vop_pkg::pol_index(addr);
    if (idx != vop_pkg::IDX_NONE) begin
      return {31'h00000000, pol_q[idx]};
    end
    unique case (addr)
      vop_pkg::OFF_FUNC21: return {16'h0000, func21_q};
      vop_pkg::OFF_RB_HI: return {30'h00000000, vout_q.upper};
      vop_pkg::OFF_RB_LO: return {16'h0000, vout_q.lower};
      vop_pkg::OFF_CLR: return {31'h00000000, clr_q};
      default: return 32'h00000000;
    endcase
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= vop_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= read_word(ar_addr);
      rresp_q <= vop_pkg::is_mapped(ar_addr) ? vop_pkg::RESP_OKAY : vop_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  for (genvar i = 0; i < vop_pkg::NUM_POL; i++) begin : g_chk
    a_active_high_drive: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (func_active[i] && !pol_q[i]) |=> virtual_out[i])
      else $error("active function with polarity 0 did not give 1");
    a_active_low_drive: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (func_active[i] && pol_q[i]) |=> !virtual_out[i])
      else $error("active function with polarity 1 did not give 0");
    a_idle_low_drive: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!func_active[i] && !pol_q[i]) |=> !virtual_out[i])
      else $error("inactive function with polarity 0 did not give 0");
    a_idle_high_drive: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!func_active[i] && pol_q[i]) |=> virtual_out[i])
      else $error("inactive function with polarity 1 did not give 1");
  end

  a_pol_reset_zero: assert property (
    @(posedge aclk) !aresetn |=> (pol_q == vop_pkg::POL_RST))
    else $error("polarity settings not zero after reset");

  a_pol_write_lands: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_idx != vop_pkg::IDX_NONE && w_strb_q[0])
      |=> pol_q[$past(wr_idx)] == $past(w_data_q[vop_pkg::POL_BIT]) && s_axi_bvalid)
    else $error("polarity write did not take effect");

  a_read_low_levels: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_fire && ar_addr == vop_pkg::OFF_RB_LO)
      |=> s_axi_rvalid && s_axi_rdata == {16'h0000, $past(virtual_out.lower)})
    else $error("readback of outputs 1 to 16 wrong");

  a_read_high_levels: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_fire && ar_addr == vop_pkg::OFF_RB_HI)
      |=> s_axi_rvalid && s_axi_rdata == {30'h00000000, $past(virtual_out.upper)})
    else $error("readback of outputs 20 and 21 wrong");

  a_clear_pulse_once: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (arm_q && clr_q) |=> vin_clear_pulse ##1 !vin_clear_pulse [*3])
    else $error("power-on clear pulse missing or repeated");

  a_clear_default_one: assert property (
    @(posedge aclk) !aresetn |=> vin_clear_enable && !vin_clear_pulse)
    else $error("power-on clear setting not 1 after reset");

  // ------------------------------------------------------------
  // levels, register bus and clear pulse checks
  // ------------------------------------------------------------
  a_levels_track: assert property (
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> virtual_out == ($past(func_active) ^ $past(pol_q)))
    else $error("terminal levels do not follow function and polarity");

  a_levels_reset_low: assert property (
    @(posedge aclk) !aresetn |=> (virtual_out == '0))
    else $error("terminal levels not low after reset");

  // a stray change here would flip terminals nobody asked to flip
  a_pol_held_idle: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(wr_fire && wr_idx != vop_pkg::IDX_NONE && w_strb_q[0]) |=> $stable(pol_q))
    else $error("polarity settings changed without a write");

  a_pol_write_okay: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_idx != vop_pkg::IDX_NONE) |=> s_axi_bvalid && s_axi_bresp == vop_pkg::RESP_OKAY)
    else $error("polarity write not answered with okay");

  a_readonly_refused: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && (aw_addr_q == vop_pkg::OFF_RB_HI || aw_addr_q == vop_pkg::OFF_RB_LO))
      |=> s_axi_bvalid && s_axi_bresp == vop_pkg::RESP_SLVERR)
    else $error("write to a readback word not refused");

  a_read_pol_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_fire && rd_idx != vop_pkg::IDX_NONE)
      |=> s_axi_rvalid && s_axi_rdata == {31'h00000000, $past(pol_q[rd_idx])})
    else $error("polarity readback wrong");

  a_read_pol_okay: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_fire && rd_idx != vop_pkg::IDX_NONE)
      |=> s_axi_rresp == vop_pkg::RESP_OKAY)
    else $error("polarity read not answered with okay");

  a_read_levels_okay: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_fire && (ar_addr == vop_pkg::OFF_RB_LO || ar_addr == vop_pkg::OFF_RB_HI))
      |=> s_axi_rresp == vop_pkg::RESP_OKAY)
    else $error("level readback not answered with okay");

  a_clear_write_lands: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_addr_q == vop_pkg::OFF_CLR && w_strb_q[0])
      |=> vin_clear_enable == $past(w_data_q[vop_pkg::CLR_BIT]))
    else $error("power-on clear setting write did not land");

  a_clear_pulse_late: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !arm_q |=> !vin_clear_pulse)
    else $error("clear pulse outside power-on");

  a_read_clear_bit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_fire && ar_addr == vop_pkg::OFF_CLR)
      |=> s_axi_rdata == {31'h00000000, $past(vin_clear_enable)})
    else $error("power-on clear setting readback wrong");

endmodule

// [tb/vop_polarity_tb.sv]
module virtual_output_polarity_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] strb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, clr_en, clr_pulse;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] fsel;
  vop_pkg::vop_levels_t fact = '0;
  vop_pkg::vop_levels_t vout;
  int miscompares = 0, n_checks = 0;
  logic [31:0] seed = 32'h00017524;
  logic [31:0] d, r;
  logic [17:0] pol;
  logic [1:0] resp;
  int cnt;

  always #4 aclk = ~aclk;

  vop_polarity dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .func_active(fact), .virtual_out(vout), .func21_select(fsel),
    .vin_clear_enable(clr_en), .vin_clear_pulse(clr_pulse));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // exactly one clear pulse follows each reset release
  task count_pulses();
    cnt = 0;
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      cnt += int'(clr_pulse);
    end
    check("clear pulse count", 32'h1, cnt);
    check("clear enable", 32'h1, {31'h0, clr_en});
  endtask

  // a bounded wait keeps a stuck handshake from hanging the run
  task axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        return;
      end
    end
    miscompares++;
    give_verdict();
  endtask

  task axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        return;
      end
    end
    miscompares++;
    give_verdict();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    count_pulses();
    for (int i = 0; i < 18; i++) begin
      axi_read(8'h0C + 8'(4 * i), d, resp);
      check("polarity reset", 32'h0, d);
    end
    axi_read(8'h54, d, resp);
    check("clear setting reset", 32'h1, d);
    $display("test reset values done");
    for (int k = 0; k < 6; k++) begin
      pol = 18'(rnd());
      if (k == 0) pol = 18'h3FFFF;
      if (k == 1) pol = 18'h00000;
      for (int i = 0; i < 18; i++) begin
        r = rnd();
        axi_write(8'h0C + 8'(4 * i), {r[31:1], pol[i]}, resp);
        check("polarity write resp", 32'(vop_pkg::RESP_OKAY), {30'h0, resp});
      end
      r = rnd();
      fact <= r[17:0];
      repeat (3) @(posedge aclk);
      check("terminal levels", {14'h0, r[17:0] ^ pol}, {14'h0, vout});
      axi_read(8'h08, d, resp);
      check("levels 1 to 16", {16'h0, r[15:0] ^ pol[15:0]}, d);
      check("levels read resp", 32'(vop_pkg::RESP_OKAY), {30'h0, resp});
      axi_read(8'h04, d, resp);
      check("levels 20 21", {30'h0, r[17:16] ^ pol[17:16]}, d);
      axi_read(8'h0C + 8'(4 * k), d, resp);
      check("polarity readback", {31'h0, pol[k]}, d);
    end
    $display("test polarity and levels done");
    r = rnd();
    axi_write(8'h00, r, resp);
    axi_read(8'h00, d, resp);
    check("function select", {16'h0, r[15:0]}, d);
    check("function select port", {16'h0, r[15:0]}, {16'h0, fsel});
    strb = 4'h2;
    axi_write(vop_pkg::OFF_FUNC21, ~r, resp);
    axi_write(vop_pkg::OFF_POL_BASE, {31'h0, ~pol[0]}, resp);
    strb = 4'hF;
    axi_read(vop_pkg::OFF_FUNC21, d, resp);
    check("function select strobe", {16'h0, ~r[15:8], r[7:0]}, d);
    axi_read(vop_pkg::OFF_POL_BASE, d, resp);
    check("polarity strobe", {31'h0, pol[0]}, d);
    axi_write(8'h54, 32'h00000000, resp);
    @(posedge aclk);
    check("clear enable off", 32'h0, {31'h0, clr_en});
    axi_read(8'h54, d, resp);
    check("clear setting off", 32'h0, d);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    count_pulses();
    check("levels after reset", {14'h0, fact}, {14'h0, vout});
    axi_read(vop_pkg::OFF_POL_LAST, d, resp);
    check("polarity after reset", 32'h0, d);
    $display("test settings done");
    axi_read(8'h58, d, resp);
    check("unmapped read resp", 32'(vop_pkg::RESP_SLVERR), {30'h0, resp});
    check("unmapped read data", 32'h0, d);
    axi_read(8'h0D, d, resp);
    check("unaligned read resp", 32'(vop_pkg::RESP_SLVERR), {30'h0, resp});
    axi_write(8'h08, 32'hFFFFFFFF, resp);
    check("readonly write resp", 32'(vop_pkg::RESP_SLVERR), {30'h0, resp});
    axi_write(8'hFC, 32'hFFFFFFFF, resp);
    check("unmapped write resp", 32'(vop_pkg::RESP_SLVERR), {30'h0, resp});
    $display("test refusals done");
    give_verdict();
  end
endmodule
